// ===== src/usc_baud_gen.v
// Baud rate generator: reloadable twelve-bit down-counter
`timescale 1ns/1ps
`default_nettype none
`include "usc_defs.vh"
module usc_baud_gen
(
  input  wire        clk,
  input  wire        rst_b,
  input  wire [11:0] divisor,
  input  wire        reload,
  output reg         tick
);
  reg [11:0] cnt_q;

  // Divisor+1 system clocks between ticks
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= `USC_RST_DIV;
      tick  <= 1'b0;
    end
    else if (reload)
    begin
      cnt_q <= divisor;
      tick  <= 1'b0;
    end
    else if (cnt_q == 12'h000)
    begin
      cnt_q <= divisor;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q - 12'h001;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== src/usc_defs.vh
// Constants for the serial clock and frame-format core
//
// Notes on behaviour
// - Baud counter counts down, reloads on zero/low write
// - One tick per zero; rate clock over divisor+1
// - Divisor is twelve bits, high and low
// - Transmit divides tick by 16, 8 or 2
// - Receiver uses raw tick, 16/8/2 state recovery
// - Four clock modes; sync select, double speed bit
// - Clock direction picks master/slave; pin idle async
// - Double speed halves samples per bit, 16 to 8
// - External clock synchronised then edge detected
// - Sample on edge opposite to data change
// - Polarity zero: change rising, sample falling
// - Five to nine bits, parity, one/two stops
// - Start, data LSB first, parity, stops
// - Line idles high; stop bits high
// - Fields select size, parity and stop count
// - One format shared by both directions
// - Receiver checks first stop bit only
// - Parity is xor of data, inverted odd
// - One transmit buffer ahead of shift register
// - Two-entry receive buffer; frame/overrun/parity errors
// - Buffer-empty flag set while buffer holds nothing
// - Done flag when frame out, buffer empty
`ifndef USC_DEFS_VH
`define USC_DEFS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define USC_A_CTRL_A    8'h00
`define USC_A_CTRL_B    8'h04
`define USC_A_CTRL_C    8'h08
`define USC_A_BAUD_LO   8'h0c
`define USC_A_BAUD_HI   8'h10
`define USC_A_DATA      8'h14
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USC_A_DBL       0
`define USC_A_TXE       1
`define USC_A_TXC       2
`define USC_A_RXC       3
`define USC_A_FE        4
`define USC_A_PE        5
`define USC_A_OVR       6
`define USC_B_TXEN      0
`define USC_B_RXEN      1
`define USC_B_TXB8      2
`define USC_B_RXB8      3
`define USC_C_CSZ_LO    0
`define USC_C_CSZ_HI    2
`define USC_C_UPM_LO    3
`define USC_C_UPM_HI    4
`define USC_C_SBS       5
`define USC_C_POL       6
`define USC_C_MSEL      7
`define USC_C_XDIR      8
// ----------------------------------------------------------------
// Encodings and counts
// ----------------------------------------------------------------
`define USC_CSZ_9       3'h7
`define USC_BITS_MIN    4'h5
`define USC_BITS_DEF    4'h8
`define USC_BITS_9      4'h9
`define USC_SMP_LAST_N  4'hf
`define USC_SMP_LAST_D  4'h7
`define USC_SMP_MID_N   4'h7
`define USC_SMP_MID_D   4'h3
`define USC_RX_SH_W     4'hb
`define USC_RST_DIV     12'h000
`endif

// ===== src/usc_pin_sync.v
// Two-flop pin synchroniser with edge detector
`timescale 1ns/1ps
`default_nettype none
module usc_pin_sync
#(
  parameter [0:0] INIT = 1'b0
)
(
  input  wire clk,
  input  wire rst_b,
  input  wire pin,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg sync_q;
  reg last_q;

  // Only sync_q reads the first flop; edges come from later stages
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= INIT;
      sync_q <= INIT;
      last_q <= INIT;
    end
    else
    begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge pulses arrive two clocks after the pin moves
  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;
endmodule
`default_nettype wire

// ===== src/usc_top.v
// Serial transceiver clock, frame and register core with APB slave
`timescale 1ns/1ps
`default_nettype none
`include "usc_defs.vh"
module usc_top
(
  input  wire        CLOCK,
  input  wire        RST_B,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        SERIAL_IN_PIN,
  output reg         SERIAL_OUT_PIN,
  input  wire        XFER_CLOCK_IN,
  output reg         XFER_CLOCK_OUT,
  output reg         XFER_CLOCK_OE
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Data bit count from the character size field
  function [3:0] bits_of;
    input [2:0] csz;
    begin
      if (csz == `USC_CSZ_9)
        bits_of = `USC_BITS_9;
      else if (csz[2])
        bits_of = `USC_BITS_DEF;
      else
        bits_of = `USC_BITS_MIN + {2'b00, csz[1:0]};
    end
  endfunction

  // Mask keeping the low n data bits
  function [8:0] mask_of;
    input [3:0] n;
    begin
      mask_of = 9'h1ff >> (4'h9 - n);
    end
  endfunction

  // Parity over the character, inverted for odd
  function par_of;
    input [8:0] d;
    input [3:0] n;
    input       odd;
    begin
      par_of = (^(d & mask_of(n))) ^ odd;
    end
  endfunction

  // Bits after the start bit: data, parity, then ones for stops
  function [11:0] frame_of;
    input [8:0] d;
    input [3:0] n;
    input [1:0] upm;
    reg   [11:0] f;
    begin
      f = {3'h7, d & mask_of(n)} | ~{3'h7, mask_of(n)};
      if (upm[1])
        f[n] = par_of(d, n, upm[0]);
      frame_of = f;
    end
  endfunction

  // Decode of the mapped offsets
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `USC_A_CTRL_A) || (a == `USC_A_CTRL_B) ||
               (a == `USC_A_CTRL_C) || (a == `USC_A_BAUD_LO) ||
               (a == `USC_A_BAUD_HI) || (a == `USC_A_DATA);
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers and bus strobes
  // ----------------------------------------------------------------
  reg        dbl_q;
  reg        txen_q;
  reg        rxen_q;
  reg        txb8_q;
  reg  [2:0] csz_q;
  reg  [1:0] upm_q;
  reg        sbs_q;
  reg        pol_q;
  reg        msel_q;
  reg        xdir_q;
  reg  [11:0] div_q;
  reg        rd_ok_q;

  wire setup = PSEL & ~PENABLE;
  wire acc   = PSEL & PENABLE & PREADY;
  wire wr    = acc & PWRITE & ~PSLVERR;
  wire rd    = acc & ~PWRITE & ~PSLVERR;
  wire lo_wr = wr & (PADDR == `USC_A_BAUD_LO);

  // One format shared by transmitter and receiver
  wire [3:0] nbits = bits_of(csz_q);
  wire       pen   = upm_q[1];
  wire       sync_m = msel_q & xdir_q;
  wire       sync_s = msel_q & ~xdir_q;

  // Software writes take effect at the completing access edge
  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      dbl_q  <= 1'b0;
      txen_q <= 1'b0;
      rxen_q <= 1'b0;
      txb8_q <= 1'b0;
      csz_q  <= 3'h0;
      upm_q  <= 2'h0;
      sbs_q  <= 1'b0;
      pol_q  <= 1'b0;
      msel_q <= 1'b0;
      xdir_q <= 1'b0;
      div_q  <= `USC_RST_DIV;
    end
    else if (wr)
    begin
      case (PADDR)
        `USC_A_CTRL_A:
          dbl_q <= PWDATA[`USC_A_DBL];
        `USC_A_CTRL_B:
        begin
          txen_q <= PWDATA[`USC_B_TXEN];
          rxen_q <= PWDATA[`USC_B_RXEN];
          txb8_q <= PWDATA[`USC_B_TXB8];
        end
        `USC_A_CTRL_C:
        begin
          csz_q  <= PWDATA[`USC_C_CSZ_HI:`USC_C_CSZ_LO];
          upm_q  <= PWDATA[`USC_C_UPM_HI:`USC_C_UPM_LO];
          sbs_q  <= PWDATA[`USC_C_SBS];
          pol_q  <= PWDATA[`USC_C_POL];
          msel_q <= PWDATA[`USC_C_MSEL];
          xdir_q <= PWDATA[`USC_C_XDIR];
        end
        `USC_A_BAUD_LO:
          div_q[7:0] <= PWDATA[7:0];
        `USC_A_BAUD_HI:
          div_q[11:8] <= PWDATA[3:0];
        default:
          dbl_q <= dbl_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock generation
  // ----------------------------------------------------------------
  wire tick;
  wire rxd;
  wire x_rise;
  wire x_fall;

  usc_baud_gen u_baud
  (
    .clk     (CLOCK),
    .rst_b   (RST_B),
    .divisor (div_q),
    .reload  (lo_wr),
    .tick    (tick)
  );

  usc_pin_sync #(.INIT(1'b0)) u_xck
  (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .pin   (XFER_CLOCK_IN),
    .level (),
    .rise  (x_rise),
    .fall  (x_fall)
  );

  usc_pin_sync #(.INIT(1'b1)) u_rxd
  (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .pin   (SERIAL_IN_PIN),
    .level (rxd),
    .rise  (),
    .fall  ()
  );

  // Double speed only counts in async; msel_q masks it off in sync
  wire       dbl  = dbl_q & ~msel_q;
  wire [3:0] last = dbl ? `USC_SMP_LAST_D : `USC_SMP_LAST_N;
  wire [3:0] mid  = dbl ? `USC_SMP_MID_D : `USC_SMP_MID_N;
  reg  [3:0] pre_q;

  // Master edges come from the toggling clock pin flop
  wire m_rise = tick & sync_m & ~XFER_CLOCK_OUT;
  wire m_fall = tick & sync_m & XFER_CLOCK_OUT;
  wire c_rise = sync_m ? m_rise : (sync_s & x_rise);
  wire c_fall = sync_m ? m_fall : (sync_s & x_fall);
  wire chg    = pol_q ? c_fall : c_rise;
  wire smp    = pol_q ? c_rise : c_fall;
  wire tx_step = msel_q ? chg : (tick & (pre_q == last));

  // Transmit prescaler and master clock output
  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pre_q          <= 4'h0;
      XFER_CLOCK_OUT <= 1'b0;
      XFER_CLOCK_OE  <= 1'b0;
    end
    else
    begin
      if (tick)
        pre_q <= (pre_q == last) ? 4'h0 : pre_q + 4'h1;
      // Toggle per tick halves the rate: divide by two in master
      if (sync_m && tick)
        XFER_CLOCK_OUT <= ~XFER_CLOCK_OUT;
      else if (!sync_m)
        XFER_CLOCK_OUT <= pol_q;
      XFER_CLOCK_OE <= sync_m;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  reg        txbuf_full_q;
  reg  [8:0] txbuf_q;
  reg        tx_busy_q;
  reg [11:0] tx_sh_q;
  reg  [3:0] tx_left_q;
  reg        tx_done_q;

  wire data_wr = wr & (PADDR == `USC_A_DATA);
  wire txc_clr = wr & (PADDR == `USC_A_CTRL_A) & PWDATA[`USC_A_TXC];
  wire tx_load = tx_step & txen_q & txbuf_full_q &
                 (!tx_busy_q || tx_left_q == 4'h0);
  wire tx_end  = tx_step & tx_busy_q & (tx_left_q == 4'h0) &
                 ~txbuf_full_q;
  wire [3:0] tx_len = nbits + {3'h0, pen} + {3'h0, sbs_q} + 4'h1;

  // Buffer, shifter and line; next frame loads at last stop bit
  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      txbuf_full_q   <= 1'b0;
      txbuf_q        <= 9'h000;
      tx_busy_q      <= 1'b0;
      tx_sh_q        <= 12'hfff;
      tx_left_q      <= 4'h0;
      tx_done_q      <= 1'b0;
      SERIAL_OUT_PIN <= 1'b1;
    end
    else
    begin
      if (tx_load)
        txbuf_full_q <= 1'b0;
      else if (data_wr && !txbuf_full_q)
      begin
        txbuf_full_q <= 1'b1;
        txbuf_q      <= {txb8_q, PWDATA[7:0]};
      end
      if (tx_load)
      begin
        SERIAL_OUT_PIN <= 1'b0;
        tx_sh_q   <= frame_of(txbuf_q, nbits, upm_q);
        tx_left_q <= tx_len;
        tx_busy_q <= 1'b1;
      end
      else if (tx_step && tx_busy_q && tx_left_q != 4'h0)
      begin
        SERIAL_OUT_PIN <= tx_sh_q[0];
        tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
      else if (tx_end || !txen_q || !tx_busy_q)
      begin
        SERIAL_OUT_PIN <= 1'b1;
        tx_busy_q      <= 1'b0;
      end
      // A completing frame wins over a clear in the same cycle
      if (tx_end)
        tx_done_q <= 1'b1;
      else if (txc_clr)
        tx_done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  localparam [1:0] RX_IDLE  = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_BITS  = 2'h2;

  reg  [1:0] rx_st_q;
  reg  [3:0] rx_cnt_q;
  reg  [3:0] rx_bit_q;
  reg [10:0] rx_sh_q;
  reg [10:0] rxf_mem [0:1];
  reg        rxf_wp_q;
  reg        rxf_rp_q;
  reg  [1:0] rxf_cnt_q;
  reg        ovr_q;

  wire [3:0] rx_total = nbits + {3'h0, pen} + 4'h1;
  wire       rx_step  = msel_q ? smp : (tick & (rx_cnt_q == last));
  wire       rx_fin   = (rx_st_q == RX_BITS) & rx_step &
                        (rx_bit_q == rx_total - 4'h1);
  wire       pop      = rd & (PADDR == `USC_A_DATA) & rd_ok_q;

  // Align the captured frame and check it
  reg [10:0] rx_full;
  reg [10:0] rx_al;
  reg  [8:0] rx_data;
  reg        rx_pe;
  reg        rx_fe;
  always @*
  begin
    rx_full = {rxd, rx_sh_q[10:1]};
    rx_al   = rx_full >> (`USC_RX_SH_W - rx_total);
    rx_data = rx_al[8:0] & mask_of(nbits);
    rx_pe   = pen & (rx_al[nbits] ^ par_of(rx_data, nbits, upm_q[0]));
    rx_fe   = ~rxd;
  end

  // Async: mid-start check then one sample per bit; sync: each sample edge
  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rx_st_q  <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 11'h000;
    end
    else if (!rxen_q)
      rx_st_q <= RX_IDLE;
    else
    begin
      case (rx_st_q)
        RX_IDLE:
        begin
          rx_cnt_q <= 4'h0;
          rx_bit_q <= 4'h0;
          if (msel_q && smp && !rxd)
            rx_st_q <= RX_BITS;
          else if (!msel_q && tick && !rxd)
            rx_st_q <= RX_START;
        end
        RX_START:
          if (tick)
          begin
            if (rx_cnt_q == mid)
            begin
              rx_cnt_q <= 4'h0;
              rx_st_q  <= rxd ? RX_IDLE : RX_BITS;
            end
            else
              rx_cnt_q <= rx_cnt_q + 4'h1;
          end
        RX_BITS:
        begin
          if (tick)
            rx_cnt_q <= (rx_cnt_q == last) ? 4'h0 : rx_cnt_q + 4'h1;
          if (rx_step)
          begin
            rx_sh_q  <= {rxd, rx_sh_q[10:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_fin)
              rx_st_q <= RX_IDLE;
          end
        end
        default:
          rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Two-entry receive buffer with overrun; a pop in the same cycle makes room for a push
  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rxf_wp_q  <= 1'b0;
      rxf_rp_q  <= 1'b0;
      rxf_cnt_q <= 2'h0;
      ovr_q     <= 1'b0;
    end
    else
    begin
      if (rx_fin && (rxf_cnt_q != 2'h2 || pop))
      begin
        rxf_mem[rxf_wp_q] <= {rx_pe, rx_fe, rx_data};
        rxf_wp_q <= ~rxf_wp_q;
      end
      if (pop)
        rxf_rp_q <= ~rxf_rp_q;
      if (rx_fin && !pop && rxf_cnt_q != 2'h2)
        rxf_cnt_q <= rxf_cnt_q + 2'h1;
      else if (pop && !rx_fin)
        rxf_cnt_q <= rxf_cnt_q - 2'h1;
      if (rx_fin && !pop && rxf_cnt_q == 2'h2)
        ovr_q <= 1'b1;
      else if (pop)
        ovr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB read path and answer
  // ----------------------------------------------------------------
  wire [10:0] head = rxf_mem[rxf_rp_q];
  wire        rx_any = (rxf_cnt_q != 2'h0);
  reg  [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      `USC_A_CTRL_A:
      begin
        rd_mux[`USC_A_DBL] = dbl_q;
        rd_mux[`USC_A_TXE] = ~txbuf_full_q;
        rd_mux[`USC_A_TXC] = tx_done_q;
        rd_mux[`USC_A_RXC] = rx_any;
        rd_mux[`USC_A_FE]  = rx_any & head[9];
        rd_mux[`USC_A_PE]  = rx_any & head[10];
        rd_mux[`USC_A_OVR] = ovr_q;
      end
      `USC_A_CTRL_B:
      begin
        rd_mux[`USC_B_TXEN] = txen_q;
        rd_mux[`USC_B_RXEN] = rxen_q;
        rd_mux[`USC_B_TXB8] = txb8_q;
        rd_mux[`USC_B_RXB8] = rx_any & head[8];
      end
      `USC_A_CTRL_C:
        rd_mux[8:0] = {xdir_q, msel_q, pol_q, sbs_q, upm_q, csz_q};
      `USC_A_BAUD_LO:
        rd_mux[7:0] = div_q[7:0];
      `USC_A_BAUD_HI:
        rd_mux[3:0] = div_q[11:8];
      `USC_A_DATA:
        rd_mux[8:0] = rx_any ? head[8:0] : 9'h000;
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // Registered answer: one wait-free access cycle after each setup
  always @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      rd_ok_q <= 1'b0;
    end
    else
    begin
      PREADY  <= setup;
      PSLVERR <= setup & ~mapped(PADDR);
      PRDATA  <= (setup && !PWRITE) ? rd_mux : 32'h0000_0000;
      rd_ok_q <= setup & rx_any;   // Pop only what was really read
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
`include "usc_defs.vh"
module tb;
  logic        CLOCK = 1'h0, RST_B = 1'h0, PSEL = 1'h0;
  logic        PENABLE = 1'h0, PWRITE = 1'h0, re, lv;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, rv, v, ex, mk;
  wire logic   PREADY, PSLVERR, SER_IN, SER_OUT, XCK_IN, XCK_OUT, XCK_OE;
  wire logic [31:0] PRDATA;
  wire logic [15:0] got;
  int          mismatches = 0, num_checks = 0, cyc = 0, t, n, bl, ln, k;
  int          nt [5] = '{5, 7, 8, 9, 6};
  logic [2:0]  ct [5] = '{3'h0, 3'h2, 3'h3, 3'h7, 3'h1};
  logic [1:0]  pt [5] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3};
  logic        st [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
  logic        dt [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
  logic [7:0]  vt [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0]  xt [5] = '{8'h15, 8'h4b, 8'hc6, 8'h3a, 8'h2d};
  always #12.5 CLOCK = ~CLOCK;
  usc_top u_dut (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SERIAL_IN_PIN(SER_IN), .SERIAL_OUT_PIN(SER_OUT),
    .XFER_CLOCK_IN(XCK_IN), .XFER_CLOCK_OUT(XCK_OUT),
    .XFER_CLOCK_OE(XCK_OE));
  usc_partner u_peer (.clk(CLOCK), .tx_line(SER_OUT), .rx_line(SER_IN),
    .sck(XCK_IN), .got(got));
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Request held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    PSEL    <= 1'h1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLOCK);
    PENABLE <= 1'h1;
    @(posedge CLOCK);
    while (PREADY !== 1'h1 && i < 100)
    begin
      i++;
      @(posedge CLOCK);
    end
    if (i == 100)
      mismatches++;
    rv      = PRDATA;
    re      = PSLVERR;
    PSEL    <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CLOCK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    apb(1'h0, a, 32'h0);
    chk(rv & m, x);
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic x);
    for (int i = 0; i < 500 && rv[b] !== x; i++)
      apb(1'h0, a, 32'h0);
    chk({31'h0, rv[b]}, {31'h0, x});
  endtask
  // Mid-bit samples from the start edge
  task automatic cap(input int nb, input int len, output logic [31:0] o);
    o = 32'h0;
    for (int i = 0; i < 3000 && SER_OUT !== 1'h0; i++)
      @(posedge CLOCK);
    repeat (len / 2) @(posedge CLOCK);
    for (int i = 0; i < nb; i++)
    begin
      o[i] = SER_OUT;
      repeat (len) @(posedge CLOCK);
    end
  endtask
  // Frame bits: start, data, parity, ones
  function automatic logic [15:0] fr(input logic [8:0] d, input int nb,
                                     input logic [1:0] pm, input logic sb);
    logic [15:0] f;
    logic        p;
    f    = 16'hffff;
    f[0] = 1'h0;
    p    = pm[0];
    for (int i = 0; i < nb; i++)
    begin
      f[i + 1] = d[i];
      p        = p ^ d[i];
    end
    if (pm[1])
      f[nb + 1] = p;
    return f;
  endfunction
  // Runaway guard
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      final_report;
    end
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge CLOCK);
    RST_B <= 1'h1;
    @(posedge CLOCK);
    rd(`USC_A_CTRL_A, 32'hff, 32'h02);
    rd(`USC_A_CTRL_C, 32'h1ff, 32'h0);
    apb(1'h0, 8'h18, 32'h0);
    chk({re, rv[30:0]}, 32'h80000000);
    $display("test reset done");
    for (t = 0; t < 5; t++)
    begin
      n  = nt[t];
      bl = (dt[t] ? 8 : 16) * (vt[t] + 1);
      ln = n + 2 + pt[t][1] + st[t];
      mk = (32'h1 << ln) - 32'h1;
      wr(`USC_A_CTRL_C, {26'h0, st[t], pt[t], ct[t]});
      wr(`USC_A_CTRL_A, {29'h0, 1'h1, 1'h0, dt[t]});
      wr(`USC_A_BAUD_HI, 32'h0);
      wr(`USC_A_BAUD_LO, {24'h0, vt[t]});
      wr(`USC_A_CTRL_B, 32'h7);
      ex = ({16'h0, fr({1'h1, xt[t]}, n, pt[t], st[t])} & mk)
         | ({16'h0, fr({1'h1, ~xt[t]}, n, pt[t], st[t])} << ln);
      fork
        cap(2 * ln, bl, v);
        begin
          wr(`USC_A_DATA, {24'h0, xt[t]});
          poll(`USC_A_CTRL_A, 1, 1'h1);
          wr(`USC_A_DATA, {24'h0, ~xt[t]});
        end
      join
      mk = (mk << ln) | mk;
      chk(v & mk, ex & mk);
      poll(`USC_A_CTRL_A, 2, 1'h1);
    end
    $display("test transmit done");
    wr(`USC_A_CTRL_C, 32'h33);
    wr(`USC_A_CTRL_A, 32'h4);
    u_peer.send_async(fr(9'h0a5, 8, 2'h2, 1'h1), 12, 16);
    u_peer.send_async(fr(9'h03c, 8, 2'h2, 1'h1) ^ 16'h0200, 12, 16);
    u_peer.send_async(fr(9'h011, 8, 2'h2, 1'h1), 12, 16);
    rd(`USC_A_CTRL_A, 32'h78, 32'h48);
    rd(`USC_A_DATA, 32'hff, 32'ha5);
    rd(`USC_A_CTRL_A, 32'h78, 32'h28);
    rd(`USC_A_DATA, 32'hff, 32'h3c);
    rd(`USC_A_CTRL_A, 32'h78, 32'h00);
    u_peer.send_async(fr(9'h081, 8, 2'h2, 1'h1) ^ 16'h0400, 12, 16);
    rd(`USC_A_CTRL_A, 32'h78, 32'h18);
    rd(`USC_A_DATA, 32'hff, 32'h81);
    $display("test receive done");
    wr(`USC_A_BAUD_HI, 32'h1);
    wr(`USC_A_BAUD_LO, 32'h0);
    wr(`USC_A_CTRL_C, 32'h180);
    repeat (2)
    begin
      lv = XCK_OUT;
      for (k = 0; k < 600 && XCK_OUT === lv; k++)
        @(posedge CLOCK);
    end
    chk(k, 32'd257);
    chk({31'h0, XCK_OE}, 32'h1);
    wr(`USC_A_BAUD_HI, 32'h0);
    wr(`USC_A_BAUD_LO, 32'h0);
    $display("test master done");
    for (t = 0; t < 2; t++)
    begin
      wr(`USC_A_CTRL_C, 32'h83 | (t << 6));
      wr(`USC_A_DATA, 32'h5a);
      u_peer.send_sync(fr(9'h0c3, 8, 2'h0, 1'h0), 10, t[0]);
      v = {16'h0, fr(9'h05a, 8, 2'h0, 1'h0)};
      chk({22'h0, got[9:0]}, v & 32'h3ff);
      rd(`USC_A_DATA, 32'hff, 32'hc3);
    end
    $display("test slave done");
    final_report;
  end
endmodule
`default_nettype wire

// ===== verif/usc_asserts.sv
// Concurrent checks on the serial core's pins
`timescale 1ns/1ps
`default_nettype none
`include "usc_defs.vh"
module usc_asserts
(
  input wire logic        CLOCK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        SERIAL_IN_PIN,
  input wire logic        SERIAL_OUT_PIN,
  input wire logic        XFER_CLOCK_IN,
  input wire logic        XFER_CLOCK_OUT,
  input wire logic        XFER_CLOCK_OE
);
  // ------------------------------------------------------------
  // Shadow of the mode bits
  // ------------------------------------------------------------
  logic [8:0] cfg_q;
  logic       txen_q;
  logic [1:0] age_q;
  wire logic  acc = PSEL && PENABLE && PREADY && PWRITE;
  // Pin checks wait three clocks after a mode write
  always_ff @(posedge CLOCK or negedge RST_B)
    if (!RST_B)
    begin
      cfg_q  <= 9'h000;
      txen_q <= 1'h0;
      age_q  <= 2'h0;
    end
    else
    begin
      if (acc && PADDR == `USC_A_CTRL_C)
        cfg_q <= PWDATA[8:0];
      if (acc && PADDR == `USC_A_CTRL_B)
        txen_q <= PWDATA[0];
      if (acc && (PADDR == `USC_A_CTRL_C || PADDR == `USC_A_CTRL_B))
        age_q <= 2'h0;
      else if (age_q != 2'h3)
        age_q <= age_q + 2'h1;
    end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_B);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_ready_setup;
    PSEL && !PENABLE |=> PREADY ##1 !PREADY;
  endproperty
  property p_ready_cause;
    PREADY |-> $past(PSEL) && !$past(PENABLE);
  endproperty
  property p_rdata_quiet;
    !PREADY |-> PRDATA == 32'h0;
  endproperty
  property p_err_ready;
    PSLVERR |-> PREADY;
  endproperty
  property p_err_map;
    PREADY && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > `USC_A_DATA);
  endproperty
  property p_tx_off;
    age_q == 2'h3 && !txen_q |-> SERIAL_OUT_PIN;
  endproperty
  property p_oe_mode;
    age_q == 2'h3 |-> XFER_CLOCK_OE == (cfg_q[7] && cfg_q[8]);
  endproperty
  property p_clk_rest;
    age_q == 2'h3 && !(cfg_q[7] && cfg_q[8]) |-> XFER_CLOCK_OUT == cfg_q[6];
  endproperty
  a_ready_setup: assert property (p_ready_setup)
    else $error("no ready after setup");
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without setup");
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data outside access");
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  a_err_map: assert property (p_err_map)
    else $error("bad error flag");
  a_tx_off: assert property (p_tx_off)
    else $error("line low with transmitter off");
  a_oe_mode: assert property (p_oe_mode)
    else $error("clock drive wrong for mode");
  a_clk_rest: assert property (p_clk_rest)
    else $error("clock not at polarity");
  c_write: cover property (acc);
  c_error: cover property (PSLVERR);
  c_master: cover property (XFER_CLOCK_OE);
  c_start: cover property ($fell(SERIAL_OUT_PIN));
endmodule
bind usc_top usc_asserts u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
  .XFER_CLOCK_IN(XFER_CLOCK_IN), .XFER_CLOCK_OUT(XFER_CLOCK_OUT),
  .XFER_CLOCK_OE(XFER_CLOCK_OE));
`default_nettype wire

// ===== verif/usc_partner.sv
// Remote serial transceiver model
`timescale 1ns/1ps
`default_nettype none
module usc_partner
#(
  parameter int HALF = 8  // Under a quarter rate
)
(
  input  wire logic        clk,
  input  wire logic        tx_line,
  output var  logic        rx_line,
  output var  logic        sck,
  output var  logic [15:0] got
);
  // Line idles high, clock stands still
  initial
  begin
    rx_line = 1'h1;
    sck     = 1'h0;
    got     = 16'h0;
  end
  // Async frame, bit 0 first
  task automatic send_async(input logic [15:0] b, input int n, input int bl);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= b[i];
      repeat (bl) @(posedge clk);
    end
    rx_line <= 1'h1;
    @(posedge clk);
  endtask
  // Sync frame: change edge, then sample edge
  task automatic send_sync(input logic [15:0] b, input int n, input logic pol);
    sck <= pol;
    repeat (4 * HALF) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      sck     <= ~pol;
      rx_line <= b[i];
      repeat (HALF) @(posedge clk);
      sck     <= pol;
      got[i]  <= tx_line;
      repeat (HALF) @(posedge clk);
    end
    rx_line <= 1'h1;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire
